// ---- src/nor_flash_host.v ----
// Host controller driving an asynchronous parallel NOR flash bus
`timescale 1ns/1ps
`include "nor_host_consts.vh"
// Contract
// - Read: select and gate low, strobe high
// - Write: strobe and select low, gate high
// - Accelerate only during two-cycle programming (code: flash_accel_req on any write with req_accel, held to next read, reset or write without req_accel)
// - Host restarts operations interrupted by reset (code only pulses reset_aborted with rsp_valid after each reset request)
module nor_flash_host #(
  parameter AW = 22,
  parameter RESET_PULSE_NS = `RESET_PULSE_NS
) (
  input wire mclk,
  input wire arst_n,
  input wire req_valid,
  input wire [1:0] req_op,
  input wire [AW-1:0] req_addr,
  input wire [15:0] req_wdata,
  input wire req_accel,
  input wire byte_mode,
  output reg req_ready,
  output reg rsp_valid,
  output reg [15:0] rsp_rdata,
  output reg reset_aborted,
  output reg flash_ce_n,
  output reg flash_oe_n,
  output reg flash_we_n,
  output reg flash_reset_n,
  output reg flash_byte_n,
  output reg flash_accel_req,
  output reg [AW-1:0] flash_addr,
  input wire [15:0] flash_dq_in,
  output reg [15:0] flash_dq_out,
  output reg flash_dq_oe_n
);
  function [`CNT_W-1:0] ns2cyc;
    input integer ns;
    integer c;
    begin
      c = (ns * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;
      if (c < 1)
        c = 1;
      ns2cyc = c[`CNT_W-1:0];
    end
  endfunction
  localparam [`CNT_W-1:0] ACC_CYC = ns2cyc(`ADDR_ACCESS_NS);
  localparam [`CNT_W-1:0] CE_CYC = ns2cyc(`SELECT_ACCESS_NS);
  localparam [`CNT_W-1:0] PACC_CYC = ns2cyc(`PAGE_ACCESS_NS);
  localparam [`CNT_W-1:0] WP_CYC = ns2cyc(`WRITE_PULSE_NS);
  localparam [`CNT_W-1:0] WH_CYC = ns2cyc(`WRITE_HIGH_NS);
  localparam [`CNT_W-1:0] RP_CYC = ns2cyc(RESET_PULSE_NS);
  localparam [`CNT_W-1:0] RH_CYC = ns2cyc(`RESET_RECOVER_NS);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_RD = 3'h1;
  localparam [2:0] S_WLOW = 3'h2;
  localparam [2:0] S_WHIGH = 3'h3;
  localparam [2:0] S_RST = 3'h4;
  localparam [2:0] S_RREC = 3'h5;
  localparam [2:0] S_LOAD = 3'h6;
  reg [2:0] state_r;
  reg [2:0] next_r;
  reg [`CNT_W-1:0] load_cnt_r;
  reg page_ok_r;
  reg [AW-1:0] page_addr_r;
  reg [15:0] dq_s1_r;
  reg [15:0] dq_s2_r;
  reg reset_pending_r;
  wire tdone;
  wire tload = (state_r == S_LOAD);
  wire same_page =
    page_ok_r && (req_addr[AW-1:`PAGE_LSB] == page_addr_r[AW-1:`PAGE_LSB]);
  nor_cycle_timer #(.W(`CNT_W)) u_timer (
    .mclk(mclk),
    .arst_n(arst_n),
    .load(tload),
    .count(load_cnt_r),
    .done(tdone)
  );
  // Data pins come from another timing domain: two flops before use
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dq_s1_r <= 16'h0000;
      dq_s2_r <= 16'h0000;
    end else begin
      dq_s1_r <= flash_dq_in;
      dq_s2_r <= dq_s1_r;
    end
  end
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= S_IDLE;
      next_r <= S_IDLE;
      load_cnt_r <= 8'h01;
      page_ok_r <= 1'b0;
      page_addr_r <= {AW{1'b0}};
      reset_pending_r <= 1'b0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
      reset_aborted <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_reset_n <= 1'b1;
      flash_byte_n <= 1'b1;
      flash_accel_req <= 1'b0;
      flash_addr <= {AW{1'b0}};
      flash_dq_out <= 16'h0000;
      flash_dq_oe_n <= 1'b1;
    end else begin
      rsp_valid <= 1'b0;
      reset_aborted <= 1'b0;
      req_ready <= 1'b0;
      case (state_r)
        S_IDLE: begin
          flash_we_n <= 1'b1;
          flash_oe_n <= 1'b1;
          flash_dq_oe_n <= 1'b1;
          flash_byte_n <= byte_mode;
          if (req_valid && !req_ready) begin
            req_ready <= 1'b1;
            flash_addr <= req_addr;
            state_r <= S_LOAD;
            if (req_op == `OP_RESET) begin
              flash_reset_n <= 1'b0;
              flash_ce_n <= 1'b1;
              flash_accel_req <= 1'b0;
              page_ok_r <= 1'b0;
              load_cnt_r <= RP_CYC;
              next_r <= S_RST;
            end else if (req_op == `OP_WRITE) begin
              flash_ce_n <= 1'b0;
              flash_we_n <= 1'b0;
              flash_dq_out <= req_wdata;
              flash_dq_oe_n <= 1'b0;
              flash_accel_req <= req_accel;
              page_ok_r <= 1'b0;
              load_cnt_r <= WP_CYC;
              next_r <= S_WLOW;
            end else begin
              flash_ce_n <= 1'b0;
              flash_oe_n <= 1'b0;
              flash_accel_req <= 1'b0;
              // Page hit only while select stayed low
              if (same_page && !flash_ce_n)
                load_cnt_r <= PACC_CYC;
              else
                load_cnt_r <= (CE_CYC > ACC_CYC) ? CE_CYC : ACC_CYC;
              page_addr_r <= req_addr;
              page_ok_r <= 1'b1;
              next_r <= S_RD;
            end
          end
        end
        S_LOAD: begin
          state_r <= next_r;
        end
        S_RD: begin
          if (tdone) begin
            // Gate stays low until this edge, so the two-flop-late sample is still valid
            rsp_rdata <= byte_mode ? dq_s2_r : {8'h00, dq_s2_r[7:0]};
            rsp_valid <= 1'b1;
            flash_oe_n <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        S_WLOW: begin
          if (tdone) begin
            flash_we_n <= 1'b1;
            flash_ce_n <= 1'b1;
            load_cnt_r <= WH_CYC;
            next_r <= S_WHIGH;
            state_r <= S_LOAD;
          end
        end
        S_WHIGH: begin
          if (tdone) begin
            flash_dq_oe_n <= 1'b1;
            rsp_valid <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        S_RST: begin
          if (tdone) begin
            flash_reset_n <= 1'b1;
            load_cnt_r <= RH_CYC;
            next_r <= S_RREC;
            state_r <= S_LOAD;
          end
        end
        S_RREC: begin
          if (tdone) begin
            reset_aborted <= 1'b1;
            rsp_valid <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule // nor_flash_host

// ---- shared/nor_host_consts.vh ----
// Timing, command and pin constants for the parallel NOR flash host
`ifndef NOR_HOST_CONSTS_VH
`define NOR_HOST_CONSTS_VH
`define CLK_PERIOD_PS 5000
`define ADDR_ACCESS_NS 90
`define SELECT_ACCESS_NS 90
`define PAGE_ACCESS_NS 25
`define WRITE_PULSE_NS 35
`define WRITE_HIGH_NS 20
`define RESET_PULSE_NS 500
`define RESET_RECOVER_NS 50
`define SLEEP_EXTRA_NS 30
`define PAGE_LSB 3
`define OP_READ 2'h0
`define OP_WRITE 2'h1
`define OP_RESET 2'h2
`define CNT_W 8
`endif

// ---- src/nor_cycle_timer.v ----
// Down-counter that measures one strobe phase in clock cycles
`timescale 1ns/1ps
module nor_cycle_timer #(
  parameter W = 8
) (
  input wire mclk,
  input wire arst_n,
  input wire load,
  input wire [W-1:0] count,
  output reg done
);
  reg [W-1:0] cnt_r;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= {W{1'b0}};
      done <= 1'b0;
    end else if (load) begin
      cnt_r <= count;
      done <= 1'b0;
    end else if (cnt_r != {W{1'b0}}) begin
      cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
      done <= (cnt_r == {{(W-1){1'b0}}, 1'b1});
    end else begin
      done <= 1'b0;
    end
  end
endmodule // nor_cycle_timer

// ---- verif/nor_flash_host_assertions.sv ----
// Pin and handshake assertions for the flash host
`timescale 1ns/1ps
module nor_flash_host_assertions (
  input wire mclk,
  input wire arst_n,
  input wire rsp_valid,
  input wire [15:0] rsp_rdata,
  input wire reset_aborted,
  input wire flash_ce_n,
  input wire flash_oe_n,
  input wire flash_we_n,
  input wire flash_reset_n,
  input wire flash_byte_n,
  input wire flash_accel_req,
  input wire flash_dq_oe_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_low2;
    !flash_reset_n ##1 !flash_reset_n;
  endsequence
  read_pins_a: assert property (
    !flash_oe_n |-> !flash_ce_n && flash_we_n) else $error("read pins");
  write_pins_a: assert property (
    !flash_we_n |-> !flash_ce_n && flash_oe_n && !flash_dq_oe_n)
    else $error("write pins");
  reset_idle_a: assert property (
    !flash_reset_n |-> flash_ce_n && flash_we_n) else $error("reset pins");
  reset_width_a: assert property (
    $fell(flash_reset_n) |-> s_low2) else $error("reset width");
  page_time_a: assert property (
    $fell(flash_oe_n) |-> !flash_oe_n [*5]) else $error("read short");
  abort_flag_a: assert property (
    reset_aborted |-> rsp_valid) else $error("abort flag");
  byte_data_a: assert property (
    rsp_valid && !flash_byte_n && !$past(flash_oe_n) |->
    rsp_rdata[15:8] == 8'h00) else $error("byte data");
  accel_write_a: assert property (
    flash_accel_req |-> flash_oe_n) else $error("accel read");
endmodule // nor_flash_host_assertions
bind nor_flash_host nor_flash_host_assertions i_chk (.*);

// ---- verif/nor_flash_model.sv ----
// Behavioural parallel NOR flash seen from its pins
`timescale 1ns/1ps
module nor_flash_model (
  input wire ce_n,
  input wire oe_n,
  input wire we_n,
  input wire reset_n,
  input wire [21:0] addr,
  input wire [15:0] din,
  output logic [15:0] dq
);
  localparam logic [7:0] ID_CODE = 8'h5C; // Arbitrary value
  logic id_mode = 1'b0;
  logic hit = 1'b0;
  logic [21:0] pa = 22'h000000;
  realtime t0 = 0;
  initial dq = 16'h0000;
  // Every command, erase and buffer loads too, passes this latch
  // Protect pin rests on its pull-up, so no sector here is locked
  // Latched by level: select and strobe rise in the same step
  always @(we_n or ce_n or reset_n or din) begin
    if (!reset_n) id_mode = 1'b0;
    else if (!we_n && !ce_n) id_mode = din == 16'h0090;
  end
  always @(ce_n or addr) begin
    hit = !ce_n && hit && addr[21:3] == pa[21:3];
    pa = addr;
    t0 = $realtime;
  end
  // Floating pins toggle so stale data never passes for a read
  // Data settles 1 ns inside each access time, so the host's edge at the
  // rounded-up count finds it valid without a race
  always #1 begin
    if (ce_n || oe_n || !reset_n ||
        $realtime - t0 < (hit ? 25 : 90) - 1) begin
      dq = ~dq;
    end else begin
      hit = 1'b1;
      dq = id_mode ? {8'h00, ID_CODE} : addr[15:0] ^ 16'hC3A5;
    end
  end
endmodule // nor_flash_model

// ---- verif/testbench.sv ----
// Self-checking bench for the parallel NOR flash host
`timescale 1ns/1ps
`include "nor_host_consts.vh"
module testbench;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic req_valid = 1'b0;
  logic [1:0] req_op = 2'h0;
  logic [21:0] req_addr = 22'h000000;
  logic [15:0] req_wdata = 16'h0000;
  logic req_accel = 1'b0;
  logic byte_mode = 1'b1;
  wire rdy, rv, abt, ce_n, oe_n, we_n, rs_n, by_n, acc, dq_oe_n;
  wire [21:0] fa;
  wire [15:0] rdata, dq_out, dq_mem;
  int n_fail = 0;
  int samples_checked = 0;
  int n;
  logic ab;
  logic ac;
  logic [15:0] rd;
  nor_flash_host #(.RESET_PULSE_NS(10)) i_dut (.mclk(mclk), .arst_n(arst_n),
    .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_accel(req_accel), .byte_mode(byte_mode),
    .req_ready(rdy), .rsp_valid(rv), .rsp_rdata(rdata),
    .reset_aborted(abt), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .flash_reset_n(rs_n), .flash_byte_n(by_n),
    .flash_accel_req(acc), .flash_addr(fa),
    .flash_dq_in(dq_oe_n ? dq_mem : dq_out), .flash_dq_out(dq_out),
    .flash_dq_oe_n(dq_oe_n));
  nor_flash_model i_mem (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .reset_n(rs_n), .addr(fa), .din(dq_out), .dq(dq_mem));
  initial forever #2.5 mclk = ~mclk;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Request held until ready is sampled, then released one edge later
  task automatic op(input logic [1:0] o, input logic [21:0] a,
      input logic [15:0] d);
    req_valid = 1'b1;
    req_op = o;
    req_addr = a;
    req_wdata = d;
    n = 0;
    while (!rdy && n < 200) begin @(posedge mclk); #1; n++; end
    @(posedge mclk); #1;
    req_valid = 1'b0;
    n = 1;
    while (!rv && n < 300) begin @(posedge mclk); #1; n++; end
    ab = abt;
    ac = acc;
    rd = rdata;
    @(posedge mclk); #1;
  endtask
  task automatic t_read;
    op(`OP_READ, 22'h000123, 16'h0000);
    check(rd, 16'hC286);
    check(16'(n), 16'h0014);
    op(`OP_READ, 22'h000126, 16'h0000);
    check(rd, 16'hC283);
    check(16'(n), 16'h0007);
    $display("t_read done");
  endtask
  task automatic t_id;
    op(`OP_WRITE, 22'h000555, 16'h0090);
    check(16'(n), 16'h000F);
    op(`OP_READ, 22'h000000, 16'h0000);
    check(rd, 16'h005C);
    req_accel = 1'b1;
    op(`OP_WRITE, 22'h000000, 16'h00A0);
    op(`OP_WRITE, 22'h000002, 16'h1234);
    check(16'(ac), 16'h0001);
    req_accel = 1'b0;
    op(`OP_READ, 22'h000008, 16'h0000);
    check(rd, 16'hC3AD);
    check(16'(ac), 16'h0000);
    $display("t_id done");
  endtask
  task automatic t_reset;
    op(`OP_WRITE, 22'h000555, 16'h0090);
    op(`OP_RESET, 22'h000000, 16'h0000);
    check(16'(ab), 16'h0001);
    check(16'(n), 16'h0010);
    op(`OP_READ, 22'h000004, 16'h0000);
    check(rd, 16'hC3A1);
    byte_mode = 1'b0;
    op(`OP_READ, 22'h000010, 16'h0000);
    check(rd, 16'h00B5);
    byte_mode = 1'b1;
    $display("t_reset done");
  endtask
  task automatic stop_test;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    stop_test;
  end
  initial begin
    repeat (3) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    t_read;
    t_id;
    t_reset;
    stop_test;
  end
endmodule // testbench
